// ===== hdl/sfrb_pkg.sv
// package: bank-0 special register map constants and types
package sfrb_pkg;
    localparam logic [7:0] OFS_INDIRECT_DATA_WINDOW = 8'h00;
    localparam logic [7:0] OFS_TIMER0_COUNT         = 8'h01;
    localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW  = 8'h02;
    localparam logic [7:0] OFS_CORE_FLAGS           = 8'h03;
    localparam logic [7:0] OFS_INDIRECT_POINTER     = 8'h04;
    localparam logic [7:0] OFS_PORT_A_IO            = 8'h05;
    localparam logic [7:0] OFS_PORT_B_IO            = 8'h06;
    localparam logic [7:0] OFS_PC_HIGH_LATCH        = 8'h0A;
    localparam logic [7:0] OFS_INTERRUPT_CONTROL    = 8'h0B;
    localparam logic [7:0] OFS_PERIPHERAL_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_TIMER1_LOW           = 8'h0E;
    localparam logic [7:0] OFS_TIMER1_HIGH          = 8'h0F;
    localparam logic [7:0] OFS_TIMER1_CONTROL       = 8'h10;
    localparam logic [7:0] OFS_TIMER2_COUNT         = 8'h11;
    localparam logic [7:0] OFS_TIMER2_CONTROL       = 8'h12;
    localparam logic [7:0] OFS_CCP_VALUE_LOW        = 8'h15;
    localparam logic [7:0] OFS_CCP_VALUE_HIGH       = 8'h16;
    localparam logic [7:0] OFS_CCP_CONTROL          = 8'h17;
    localparam logic [7:0] OFS_PWM_DEADBAND_CONTROL = 8'h18;
    localparam logic [7:0] OFS_AUTO_SHUTDOWN_CONTROL = 8'h19;
    localparam logic [7:0] OFS_ADC_RESULT           = 8'h1E;
    localparam logic [7:0] OFS_ADC_CONTROL          = 8'h1F;
    // extra register: direct address as seen by the core bank logic
    localparam logic [7:0] OFS_PC_UPPER_VIEW        = 8'h20;
    // implemented-bit masks, unimplemented bits read zero; MSK_FLAGS_WR marks the writable status bits
    localparam logic [7:0] MSK_PORT_A       = 8'h1F;
    localparam logic [7:0] MSK_PC_HIGH      = 8'h1F;
    localparam logic [7:0] MSK_IRQ_FLAGS    = 8'h47;
    localparam logic [7:0] MSK_T1_CONTROL   = 8'h3F;
    localparam logic [7:0] MSK_T2_CONTROL   = 8'h7F;
    localparam logic [7:0] MSK_AUTO_SHUT    = 8'hDF;
    localparam logic [7:0] MSK_FLAGS_WR     = 8'hE7;
    // reset values on power-on and brown-out
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_CORE_FLAGS   = 8'h18;
    localparam logic [7:0] RST_TRIS         = 8'hFF;
    localparam int         BANK_SIZE        = 128;
    localparam int         NUM_REGS         = 32;
    localparam logic [1:0] BANK0            = 2'h0;
    localparam logic [1:0] BANK1            = 2'h1;
    localparam int         FLAG_C           = 0;
    localparam int         FLAG_DC          = 1;
    localparam int         FLAG_Z           = 2;
    localparam int         FLAG_PD          = 3;
    localparam int         FLAG_TO          = 4;

    typedef enum logic [1:0] {
        SFRB_IDLE = 2'b00,
        SFRB_DONE = 2'b01
    } sfrb_state_e;

    typedef struct packed {
        logic       z;
        logic       dc;
        logic       c;
        logic       alu_owns;
    } sfrb_alu_s;
endpackage

// ===== hdl/sfrb_regmap.sv
// module: bank-0 special register map, Avalon-MM slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module sfrb_regmap (
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    input  wire logic            por_rst,
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output var  logic [31:0]     avs_readdata,
    output var  logic            avs_waitrequest,
    output var  logic [1:0]      avs_response,
    input  wire sfrb_pkg::sfrb_alu_s alu,
    input  wire logic            pc_update,
    input  wire logic [7:0]      pc_low_next,
    input  wire logic            timeout_event,
    input  wire logic            powerdown_event,
    input  wire logic            flags_restore,
    input  wire logic [4:0]      port_a_pins,
    input  wire logic [7:0]      port_b_pins,
    input  wire logic [4:0]      port_a_dir_in,
    input  wire logic [7:0]      port_b_dir_in,
    output var  logic [4:0]      port_a_latch,
    output var  logic [7:0]      port_b_latch,
    output var  logic [4:0]      port_a_oe,
    output var  logic [7:0]      port_b_oe,
    output var  logic [12:0]     program_counter,
    output var  logic [7:0]      indirect_addr,
    output var  logic            indirect_wr,
    output var  logic [7:0]      indirect_wdata,
    input  wire logic [7:0]      indirect_rdata,
    output var  logic            direct_bank
);
    logic [7:0]                 regs [sfrb_pkg::NUM_REGS];
    logic [7:0]                 core_flags;
    logic [4:0]                 pc_high_latch;
    logic [7:0]                 program_counter_low;
    logic [4:0]                 pc_upper;
    logic [7:0]                 indirect_pointer;
    sfrb_pkg::sfrb_state_e      state;
    logic [4:0]                 reg_idx;
    logic                       bank_hi;
    logic                       in_window;
    logic                       shared;
    logic                       hit_plain;
    logic                       wr_go;
    logic [7:0]                 wdat;
    logic [7:0]                 rd_val;
    logic [7:0]                 plain_mask [sfrb_pkg::NUM_REGS];

    // bit 7 of the address picks the bank; only bank 0 peripherals live here
    assign bank_hi   = avs_address[7];
    assign reg_idx   = avs_address[4:0];
    assign in_window = (avs_address[6:5] == 2'b00);
    assign shared    = in_window && (reg_idx == sfrb_pkg::OFS_INDIRECT_DATA_WINDOW[4:0]
        || reg_idx == sfrb_pkg::OFS_PROGRAM_COUNTER_LOW[4:0] || reg_idx == sfrb_pkg::OFS_CORE_FLAGS[4:0]
        || reg_idx == sfrb_pkg::OFS_INDIRECT_POINTER[4:0] || reg_idx == sfrb_pkg::OFS_PC_HIGH_LATCH[4:0]
        || reg_idx == sfrb_pkg::OFS_INTERRUPT_CONTROL[4:0]);
    // shared addresses with plain storage (irq control) must also hit from bank 1
    assign hit_plain = in_window && (!bank_hi || shared) && (plain_mask[reg_idx] != 8'h00);
    // write lands on the edge where the master sees waitrequest low, never earlier
    assign wr_go     = avs_write && avs_byteenable[0] && (state == sfrb_pkg::SFRB_DONE);
    assign wdat      = avs_writedata[7:0];

    // per-address implemented-bit mask; zero mask means no plain storage
    always_comb begin
        for (int i = 0; i < sfrb_pkg::NUM_REGS; i++) begin
            plain_mask[i] = 8'h00;
        end
        plain_mask[sfrb_pkg::OFS_TIMER0_COUNT[4:0]]          = 8'hFF;
        plain_mask[sfrb_pkg::OFS_INTERRUPT_CONTROL[4:0]]     = 8'hFF;
        plain_mask[sfrb_pkg::OFS_PERIPHERAL_IRQ_FLAGS[4:0]]  = sfrb_pkg::MSK_IRQ_FLAGS;
        plain_mask[sfrb_pkg::OFS_TIMER1_LOW[4:0]]            = 8'hFF;
        plain_mask[sfrb_pkg::OFS_TIMER1_HIGH[4:0]]           = 8'hFF;
        plain_mask[sfrb_pkg::OFS_TIMER1_CONTROL[4:0]]        = sfrb_pkg::MSK_T1_CONTROL;
        plain_mask[sfrb_pkg::OFS_TIMER2_COUNT[4:0]]          = 8'hFF;
        plain_mask[sfrb_pkg::OFS_TIMER2_CONTROL[4:0]]        = sfrb_pkg::MSK_T2_CONTROL;
        plain_mask[sfrb_pkg::OFS_CCP_VALUE_LOW[4:0]]         = 8'hFF;
        plain_mask[sfrb_pkg::OFS_CCP_VALUE_HIGH[4:0]]        = 8'hFF;
        plain_mask[sfrb_pkg::OFS_CCP_CONTROL[4:0]]           = 8'hFF;
        plain_mask[sfrb_pkg::OFS_PWM_DEADBAND_CONTROL[4:0]]  = 8'hFF;
        plain_mask[sfrb_pkg::OFS_AUTO_SHUTDOWN_CONTROL[4:0]] = sfrb_pkg::MSK_AUTO_SHUT;
        plain_mask[sfrb_pkg::OFS_ADC_RESULT[4:0]]            = 8'hFF;
        plain_mask[sfrb_pkg::OFS_ADC_CONTROL[4:0]]           = 8'hFF;
    end

    // plain peripheral storage, one static byte per address
    generate
        for (genvar g = 0; g < sfrb_pkg::NUM_REGS; g++) begin : g_reg
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    regs[g] <= sfrb_pkg::RST_ZERO;
                end else if (wr_go && hit_plain && reg_idx == 5'(g)) begin
                    regs[g] <= wdat & plain_mask[g];
                end
            end
        end
    endgenerate

    // status: bank bits writable, timeout and powerdown only by hardware
    always_ff @(posedge mclk) begin
        if (por_rst) begin
            core_flags <= sfrb_pkg::RST_CORE_FLAGS;
        end else begin
            if (wr_go && shared && reg_idx == sfrb_pkg::OFS_CORE_FLAGS[4:0]) begin
                core_flags[7:5] <= wdat[7:5];
                if (!alu.alu_owns) begin
                    core_flags[2:0] <= wdat[2:0];
                end
            end
            if (alu.alu_owns) begin
                core_flags[sfrb_pkg::FLAG_Z]  <= alu.z;
                core_flags[sfrb_pkg::FLAG_DC] <= alu.dc;
                core_flags[sfrb_pkg::FLAG_C]  <= alu.c;
            end
            if (timeout_event) begin
                core_flags[sfrb_pkg::FLAG_TO] <= 1'b0;
            end else if (flags_restore) begin
                core_flags[sfrb_pkg::FLAG_TO] <= 1'b1;
            end
            if (powerdown_event) begin
                core_flags[sfrb_pkg::FLAG_PD] <= 1'b0;
            end else if (flags_restore) begin
                core_flags[sfrb_pkg::FLAG_PD] <= 1'b1;
            end
        end
    end

    // pc latch holds until written; a PCL write or pc_update copies it to the upper pc, a latch write alone never moves pc
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pc_high_latch <= sfrb_pkg::RST_ZERO[4:0];
        end else if (wr_go && shared && reg_idx == sfrb_pkg::OFS_PC_HIGH_LATCH[4:0]) begin
            pc_high_latch <= wdat[4:0] & sfrb_pkg::MSK_PC_HIGH[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            program_counter_low <= sfrb_pkg::RST_ZERO;
            pc_upper            <= sfrb_pkg::RST_ZERO[4:0];
        end else if (wr_go && shared && reg_idx == sfrb_pkg::OFS_PROGRAM_COUNTER_LOW[4:0]) begin
            program_counter_low <= wdat;
            pc_upper            <= pc_high_latch;
        end else if (pc_update) begin
            program_counter_low <= pc_low_next;
            pc_upper            <= pc_high_latch;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            indirect_pointer <= sfrb_pkg::RST_ZERO;
        end else if (wr_go && shared && reg_idx == sfrb_pkg::OFS_INDIRECT_POINTER[4:0]) begin
            indirect_pointer <= wdat;
        end
    end

    // port latches keep their value across resets; only direction resets
    always_ff @(posedge mclk) begin
        if (wr_go && in_window && !bank_hi && reg_idx == sfrb_pkg::OFS_PORT_A_IO[4:0]) begin
            port_a_latch <= wdat[4:0];
        end
        if (wr_go && in_window && !bank_hi && reg_idx == sfrb_pkg::OFS_PORT_B_IO[4:0]) begin
            port_b_latch <= wdat;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port_a_oe <= 5'h00;
            port_b_oe <= 8'h00;
        end else begin
            port_a_oe <= ~port_a_dir_in;
            port_b_oe <= ~port_b_dir_in;
        end
    end

    // indirect window: the pointer addresses data memory, no storage here
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            indirect_wr    <= 1'b0;
            indirect_wdata <= sfrb_pkg::RST_ZERO;
        end else begin
            indirect_wr    <= wr_go && shared && reg_idx == sfrb_pkg::OFS_INDIRECT_DATA_WINDOW[4:0];
            indirect_wdata <= wdat;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            indirect_addr   <= sfrb_pkg::RST_ZERO;
            program_counter <= 13'h0000;
            direct_bank     <= 1'b0;
        end else begin
            indirect_addr   <= indirect_pointer;
            program_counter <= {pc_upper, program_counter_low};
            direct_bank     <= core_flags[5];
        end
    end

    // read mux; upper pc has no address so it never appears here
    always_comb begin
        rd_val = 8'h00;
        if (in_window) begin
            if (shared && reg_idx == sfrb_pkg::OFS_INDIRECT_DATA_WINDOW[4:0]) begin
                rd_val = indirect_rdata;
            end else if (shared && reg_idx == sfrb_pkg::OFS_PROGRAM_COUNTER_LOW[4:0]) begin
                rd_val = program_counter_low;
            end else if (shared && reg_idx == sfrb_pkg::OFS_CORE_FLAGS[4:0]) begin
                rd_val = core_flags;
            end else if (shared && reg_idx == sfrb_pkg::OFS_INDIRECT_POINTER[4:0]) begin
                rd_val = indirect_pointer;
            end else if (shared && reg_idx == sfrb_pkg::OFS_PC_HIGH_LATCH[4:0]) begin
                rd_val = {3'b000, pc_high_latch};
            end else if (shared && reg_idx == sfrb_pkg::OFS_INTERRUPT_CONTROL[4:0]) begin
                rd_val = regs[reg_idx];
            end else if (!bank_hi && reg_idx == sfrb_pkg::OFS_PORT_A_IO[4:0]) begin
                rd_val = {3'b000, port_a_pins};
            end else if (!bank_hi && reg_idx == sfrb_pkg::OFS_PORT_B_IO[4:0]) begin
                rd_val = port_b_pins;
            end else if (hit_plain) begin
                rd_val = regs[reg_idx] & plain_mask[reg_idx];
            end
        end
    end

    // one wait cycle: request in IDLE, answer in DONE, then back to IDLE
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state           <= sfrb_pkg::SFRB_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            avs_response    <= 2'b00;
        end else begin
            case (state)
                sfrb_pkg::SFRB_IDLE: begin
                    if (avs_read || avs_write) begin
                        state           <= sfrb_pkg::SFRB_DONE;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= {24'h00_0000, rd_val};
                    end else begin
                        avs_waitrequest <= 1'b1;
                    end
                end
                sfrb_pkg::SFRB_DONE: begin
                    state           <= sfrb_pkg::SFRB_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    state           <= sfrb_pkg::SFRB_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verification/sfrb_core_model.sv
// core-side model: data memory behind the window and port pin wiring
`timescale 1ns/100ps
`default_nettype none
module sfrb_core_model (
    input  wire logic       mclk,
    input  wire logic [7:0] indirect_addr,
    input  wire logic       indirect_wr,
    input  wire logic [7:0] indirect_wdata,
    output var  logic [7:0] indirect_rdata,
    input  wire logic [4:0] port_a_latch,
    input  wire logic [4:0] port_a_oe,
    input  wire logic [4:0] port_a_ext,
    output var  logic [4:0] port_a_pins,
    input  wire logic [7:0] port_b_latch,
    input  wire logic [7:0] port_b_oe,
    input  wire logic [7:0] port_b_ext,
    output var  logic [7:0] port_b_pins
);
    logic [7:0] mem [256];
    // non-trivial fill so a window read of a wrong address cannot pass by luck
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    // a pin shows the latch only where the device drives it
    assign port_a_pins = (port_a_oe & port_a_latch) | (~port_a_oe & port_a_ext);
    assign port_b_pins = (port_b_oe & port_b_latch) | (~port_b_oe & port_b_ext);
    assign indirect_rdata = mem[indirect_addr];
    always @(posedge mclk) begin
        if (indirect_wr) begin
            mem[indirect_addr] <= indirect_wdata;
        end
    end
endmodule
`default_nettype wire

// ===== verification/sfrb_regmap_chk.sv
// checker: bus answer, port direction, program counter and window-write properties
`timescale 1ns/100ps
`default_nettype none
module sfrb_regmap_chk (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic        pc_update,
    input wire logic [4:0]  port_a_dir_in,
    input wire logic [7:0]  port_b_dir_in,
    input wire logic [4:0]  port_a_oe,
    input wire logic [7:0]  port_b_oe,
    input wire logic [12:0] program_counter,
    input wire logic        indirect_wr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence taken_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence win_wr_s;
        taken_s ##0 (avs_write && avs_byteenable[0] && avs_address[6:0] == 7'h00);
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("bus answer not one cycle after request");
    idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    resp_okay_a: assert property (!avs_waitrequest |-> avs_response == 2'b00 && avs_readdata[31:8] == 24'h0)
        else $error("bad response or upper read bits");
    rdata_hold_a: assert property (avs_waitrequest && !$past(sys_rst) |-> $stable(avs_readdata))
        else $error("read data moved outside answer");
    oe_reset_a: assert property ($fell(sys_rst) |-> port_a_oe == 5'h00 && port_b_oe == 8'h00)
        else $error("port driven after reset");
    oe_follow_a: assert property (!$past(sys_rst) |=>
        port_a_oe == ~$past(port_a_dir_in) && port_b_oe == ~$past(port_b_dir_in))
        else $error("output enable not following direction");
    pc_hold_a: assert property ((!pc_update && !avs_write) [*3] |-> $stable(program_counter))
        else $error("program counter moved without update");
    win_write_a: assert property (win_wr_s |-> ##[1:2] indirect_wr)
        else $error("window write not forwarded");
    win_pulse_a: assert property (indirect_wr |=> !indirect_wr)
        else $error("window write strobe too long");
endmodule
bind sfrb_regmap sfrb_regmap_chk u_chk (.*);
`default_nettype wire

// ===== verification/tb.sv
// testbench: register map accesses over the bus with expected values
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        mclk = 1'b0, sys_rst = 1'b1, por_rst = 1'b1;
    logic        avs_read = 1'b0, avs_write = 1'b0, pc_update = 1'b0;
    logic        timeout_event = 1'b0, powerdown_event = 1'b0, flags_restore = 1'b0;
    logic [7:0]  avs_address = 8'h00, pc_low_next = 8'h00, port_b_ext = 8'hC3, port_b_dir_in = 8'hFF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rv;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [4:0]  port_a_ext = 5'h0A, port_a_dir_in = 5'h1F, port_a_pins, port_a_latch, port_a_oe;
    logic [7:0]  port_b_pins, port_b_latch, port_b_oe, indirect_addr, indirect_wdata, indirect_rdata;
    logic [1:0]  avs_response;
    logic [12:0] program_counter;
    logic        avs_waitrequest, indirect_wr, direct_bank;
    sfrb_pkg::sfrb_alu_s alu = 4'h0;
    int          failures = 0, n_compared = 0;
    localparam logic [7:0] ADR [16] = '{8'h01, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h17,
                                        8'h19, 8'h07, 8'h0D, 8'h14, 8'h1A, 8'h1D, 8'h20, 8'h81};
    localparam logic [7:0] MSK [16] = '{8'hFF, 8'h1F, 8'hFF, 8'h47, 8'hFF, 8'h3F, 8'h7F, 8'hFF,
                                        8'hDF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RST [10] = '{8'h02, 8'h0A, 8'h0C, 8'h10, 8'h11, 8'h12, 8'h17, 8'h18, 8'h19, 8'h1F};
    sfrb_regmap dut (.*);
    sfrb_core_model core (.*);
    always #4 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // both bus tasks leave one idle edge so a strobe is never set twice in a time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
    endtask
    task automatic print_verdict();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge mclk);
        foreach (RST[i]) rdc(RST[i], 32'h0);
        rd(8'h03);
        chk(rv & 32'hF8, 32'h18);
        for (int p = 0; p < 2; p++) begin
            foreach (ADR[i]) begin
                wr(ADR[i], p ? 8'h5A : 8'hFF);
                rdc(ADR[i], {24'h0, (p ? 8'h5A : 8'hFF) & MSK[i]});
            end
        end
        wr(8'h84, 8'h40);
        rdc(8'h04, 32'h40);
        wr(8'h8B, 8'h3C);
        rdc(8'h0B, 32'h3C);
        wr(8'h00, 8'h99);
        @(posedge mclk);
        chk({24'h0, core.mem[8'h40]}, 32'h99);
        rdc(8'h80, 32'h99);
        avs_byteenable <= 4'h0;
        wr(8'h0B, 8'h11);
        avs_byteenable <= 4'h1;
        rdc(8'h0B, 32'h3C);
        wr(8'h03, 8'h07);
        rdc(8'h03, 32'h1F);
        wr(8'h83, 8'h20);
        rdc(8'h03, 32'h38);
        chk({31'h0, direct_bank}, 32'h1);
        alu <= 4'h9;
        wr(8'h03, 8'h03);
        alu <= 4'h0;
        rdc(8'h03, 32'h1C);
        {timeout_event, powerdown_event} <= 2'b11;
        @(posedge mclk);
        {timeout_event, powerdown_event} <= 2'b00;
        rdc(8'h03, 32'h04);
        flags_restore <= 1'b1;
        @(posedge mclk);
        flags_restore <= 1'b0;
        rdc(8'h03, 32'h1C);
        wr(8'h8A, 8'h15);
        repeat (3) @(posedge mclk);
        chk({19'h0, program_counter}, 32'h0);
        pc_low_next <= 8'h3C;
        pc_update <= 1'b1;
        @(posedge mclk);
        pc_update <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({19'h0, program_counter}, 32'h153C);
        rdc(8'h0A, 32'h15);
        rdc(8'h05, 32'h0A);
        wr(8'h05, 8'h1F);
        wr(8'h06, 8'h5A);
        chk({27'h0, port_a_latch}, 32'h1F);
        chk({24'h0, port_b_latch}, 32'h5A);
        rdc(8'h06, 32'hC3);
        port_a_dir_in <= 5'h00;
        port_b_dir_in <= 8'h0F;
        repeat (2) @(posedge mclk);
        chk({24'h0, port_b_oe}, 32'hF0);
        rdc(8'h06, 32'h53);
        rdc(8'h05, 32'h1F);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({27'h0, port_a_oe}, 32'h0);
        chk({24'h0, port_b_oe}, 32'h0);
        chk({24'h0, port_b_latch}, 32'h5A);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rdc(8'h06, 32'h53);
        print_verdict();
    end
endmodule
`default_nettype wire
